/* File: rtl/crs_status_bank.sv */
// collision position and signal strength status registers behind an AXI4-Lite slave
`timescale 1ns/1ps
// How it works
// - power-on or chip disable clears clash position
// - clash position clears after host reads it
// - clash register holds low eight index bits
// - index bits 9,8 shown in mask bits 7,6
// - other protocols report error bit position instead
// - framing, sof, eof, parity, crc errors count
// - osc stable bit set after about 200 us
// - bits 2..0 hold main channel strength
// - bits 5..3 hold auxiliary channel strength
// - control bit 3 swaps the receive inputs
// - strength valid from receive until next transmit
// - strength latches the peak envelope value
// - strength cleared when next transmission starts
// - strength is 3-bit code, seven 4 dB steps
// - rf amplitude measured while field is off
// - level is one-sided peak-to-peak modulation
module crs_status_bank #(
    parameter int OSC_SETTLE = crs_pkg::OSC_SETTLE_CYCLES   // oscillator settle cycles
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // pins, asynchronous to aclk
    input  wire logic                 por_pin,             // power-on reset, active high
    input  wire logic                 chip_enable_pin,     // chip enable, active high
    // decoder and front end, same clock
    input  wire logic                 proto_is_14443a,     // collision reporting mode
    input  wire crs_pkg::crs_dec_evt_s dec_evt,            // collision or error event
    input  wire logic                 rx_start,            // reception begins (pulse)
    input  wire logic                 tx_start,            // transmission begins (pulse)
    input  wire logic [7:0]           first_receive_input, // envelope of first input
    input  wire logic [7:0]           second_receive_input,// envelope of second input
    input  wire logic                 rf_amp_meas,         // amplitude measure command
    input  wire logic                 field_on,            // reader field on
    input  wire logic [7:0]           rf_amp_level,        // rf amplitude sample
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);

    // decode a byte address against a register index
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        return addr[7:2] == idx;
    endfunction

    // is the index one of ours
    function automatic logic mapped(input logic [7:0] addr);
        return hit(addr, crs_pkg::IDX_CHIP_CTRL) || hit(addr, crs_pkg::IDX_IRQ_MASK) ||
               hit(addr, crs_pkg::IDX_CLASH_POS) || hit(addr, crs_pkg::IDX_STRENGTH);
    endfunction

    // ---------------- pin synchronisers ----------------
    logic [1:0] por_sync_q;   // two-stage catch of power-on pin
    logic [1:0] en_sync_q;    // two-stage catch of enable pin
    logic       powered_down; // por high or enable low, synchronised

    // pins only reach logic through the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_sync_q <= 2'b11;
            en_sync_q  <= 2'b00;
        end else begin
            por_sync_q <= {por_sync_q[0], por_pin};
            en_sync_q  <= {en_sync_q[0], chip_enable_pin};
        end
    end

    assign powered_down = por_sync_q[1] || !en_sync_q[1];

    // ---------------- bus state ----------------
    logic        awready_q, awready_d;   // address slot free
    logic        wready_q, wready_d;     // data slot free
    logic        aw_held_q, aw_held_d;   // write address waiting
    logic        w_held_q, w_held_d;     // write data waiting
    logic [7:0]  aw_addr_q, aw_addr_d;   // held write address
    logic [31:0] w_data_q, w_data_d;     // held write data
    logic [3:0]  w_strb_q, w_strb_d;     // held byte enables
    logic        bvalid_q, bvalid_d;     // write answer pending
    logic [1:0]  bresp_q, bresp_d;       // write answer code
    logic        arready_q, arready_d;   // read slot free
    logic        rvalid_q, rvalid_d;     // read answer pending
    logic [31:0] rdata_q, rdata_d;       // read answer data
    logic [1:0]  rresp_q, rresp_d;       // read answer code
    logic        do_write;               // both halves of a write are here
    logic        ar_take;                // read address accepted now
    logic        wr_ctrl;                // write lands on control register
    logic        wr_mask;                // write lands on mask register
    logic        rd_clash;               // read of the clash register

    // ---------------- block state ----------------
    logic [7:0]  ctrl_q, ctrl_d;         // chip status control
    logic [5:0]  mask_q, mask_d;         // interrupt enables, kept for readback
    logic [7:0]  clash_q, clash_d;       // clash_index_msb .. clash_index_lsb
    logic [1:0]  clash_top_q, clash_top_d; // clash_index_top, clash_index_ninth
    logic        win_q, win_d;           // measuring window open
    logic [31:0] osc_cnt_q, osc_cnt_d;   // oscillator settle counter
    logic        osc_ok_q, osc_ok_d;     // oscillator stable
    logic        evt_take;               // this event updates the position
    logic        swap;                   // receive inputs swapped
    logic        amp_mode;               // rf amplitude measurement active
    logic [7:0]  strength;               // assembled strength register
    logic [2:0]  ch_code [2];            // 0 main, 1 auxiliary
    logic [7:0]  ch_sample [2];          // sample routed to each channel

    // ---------------- write channel ----------------
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_ctrl  = do_write && hit(aw_addr_q, crs_pkg::IDX_CHIP_CTRL) && w_strb_q[0];
    assign wr_mask  = do_write && hit(aw_addr_q, crs_pkg::IDX_IRQ_MASK) && w_strb_q[0];

    // address and data are taken in either order; answer follows both
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            // read-only registers ignore the data but answer okay
            bresp_d   = mapped(aw_addr_q) ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
        end
        // a slot reopens only once its half has been used
        awready_d = !aw_held_d;
        wready_d  = !w_held_d;
    end

    // register write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= crs_pkg::RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // ---------------- read channel ----------------
    assign ar_take  = s_axi_arvalid && arready_q;
    assign rd_clash = ar_take && hit(s_axi_araddr, crs_pkg::IDX_CLASH_POS);

    // one read at a time; data is sampled in the accept cycle
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
            rdata_d  = 32'h0000_0000;
            if (hit(s_axi_araddr, crs_pkg::IDX_CHIP_CTRL)) begin
                rdata_d[7:0] = ctrl_q;
            end else if (hit(s_axi_araddr, crs_pkg::IDX_IRQ_MASK)) begin
                rdata_d[7:0] = {clash_top_q, mask_q};
            end else if (hit(s_axi_araddr, crs_pkg::IDX_CLASH_POS)) begin
                // returns the value held before the clear below
                rdata_d[7:0] = clash_q;
            end else if (hit(s_axi_araddr, crs_pkg::IDX_STRENGTH)) begin
                rdata_d[7:0] = strength;
            end
        end
        arready_d = !rvalid_d;
    end

    // register read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= crs_pkg::RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ---------------- clash position ----------------
    // collisions count in 14443 A, the listed errors in the other protocols
    assign evt_take = dec_evt.valid &&
        ((!dec_evt.is_error && proto_is_14443a) ||
         (dec_evt.is_error && !proto_is_14443a && (|dec_evt.err_kind)));

    // configuration registers and the clash position
    always_comb begin
        ctrl_d      = ctrl_q;
        mask_d      = mask_q;
        clash_d     = clash_q;
        clash_top_d = clash_top_q;
        if (wr_ctrl) begin
            ctrl_d = w_data_q[7:0];
        end
        if (wr_mask) begin
            mask_d = w_data_q[crs_pkg::MASK_TOP_LO-1:0];
        end
        // read clears; a new event in the same cycle wins over the clear
        if (rd_clash) begin
            clash_d = crs_pkg::RST_CLASH_POS;
        end
        if (evt_take) begin
            clash_d     = dec_evt.bit_index[7:0];
            clash_top_d = proto_is_14443a ? dec_evt.bit_index[9:8] : clash_top_q;
        end
        // power-down overrides everything
        if (powered_down) begin
            clash_d     = crs_pkg::RST_CLASH_POS;
            clash_top_d = 2'b00;
            ctrl_d      = crs_pkg::RST_CHIP_CTRL;
            mask_d      = crs_pkg::RST_IRQ_MASK;
        end
    end

    // register configuration and clash state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q      <= crs_pkg::RST_CHIP_CTRL;
            mask_q      <= crs_pkg::RST_IRQ_MASK;
            clash_q     <= crs_pkg::RST_CLASH_POS;
            clash_top_q <= 2'b00;
        end else begin
            ctrl_q      <= ctrl_d;
            mask_q      <= mask_d;
            clash_q     <= clash_d;
            clash_top_q <= clash_top_d;
        end
    end

    // ---------------- oscillator and window ----------------
    // counts from the moment the chip is powered; restarts on power-down
    always_comb begin
        osc_cnt_d = osc_cnt_q;
        osc_ok_d  = osc_ok_q;
        win_d     = win_q;
        if (powered_down) begin
            osc_cnt_d = 32'h0000_0000;
            osc_ok_d  = 1'b0;
        end else if (osc_cnt_q < 32'(OSC_SETTLE - 1)) begin
            osc_cnt_d = osc_cnt_q + 32'h0000_0001;
        end else begin
            osc_ok_d = 1'b1;
        end
        // window opens at receive start and closes at transmit start
        if (rx_start) begin
            win_d = 1'b1;
        end
        if (tx_start || powered_down) begin
            win_d = 1'b0;
        end
    end

    // register oscillator and window state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt_q <= 32'h0000_0000;
            osc_ok_q  <= 1'b0;
            win_q     <= 1'b0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            osc_ok_q  <= osc_ok_d;
            win_q     <= win_d;
        end
    end

    // ---------------- strength channels ----------------
    assign swap     = ctrl_q[crs_pkg::CTRL_SWAP_BIT];
    // amplitude command only counts while the field is off
    assign amp_mode = rf_amp_meas && !field_on;

    // route inputs: default main first, aux second; swapped otherwise
    always_comb begin
        ch_sample[0] = swap ? second_receive_input : first_receive_input;
        ch_sample[1] = swap ? first_receive_input : second_receive_input;
        if (amp_mode) begin
            ch_sample[0] = rf_amp_level;
        end
    end

    // one peak holder per channel
    for (genvar c = 0; c < 2; c++) begin : g_ch
        crs_peak_hold u_peak (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .clear    (tx_start || powered_down),
            .enable   (win_q || amp_mode),
            .abs_mode (amp_mode),
            .sample   (ch_sample[c]),
            .code     (ch_code[c])
        );
    end

    // bit 7 unused reads zero
    assign strength = {1'b0, osc_ok_q, ch_code[1], ch_code[0]};

endmodule

/* File: rtl/crs_pkg.sv */
// package: offsets, fields, reset values, timing and carrier types of the status bank
package crs_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [5:0] IDX_CHIP_CTRL  = 6'h00;   // chip status control
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h0D;   // interrupt mask, top clash bits
    localparam logic [5:0] IDX_CLASH_POS  = 6'h0E;   // clash_position
    localparam logic [5:0] IDX_STRENGTH   = 6'h0F;   // signal_strength_and_osc_status

    // reset values
    localparam logic [7:0] RST_CHIP_CTRL  = 8'h00;
    localparam logic [5:0] RST_IRQ_MASK   = 6'h3E;   // enables mask bits 5..1, bit 0 off
    localparam logic [7:0] RST_CLASH_POS  = 8'h00;

    // field positions
    localparam int CTRL_SWAP_BIT   = 3;   // swap receive inputs
    localparam int MASK_TOP_HI     = 7;   // clash_index_top
    localparam int MASK_TOP_LO     = 6;   // clash_index_ninth
    localparam int STR_OSC_BIT     = 6;   // oscillator stable
    localparam int STR_AUX_LO      = 3;   // aux_strength_lsb .. aux_strength_msb
    localparam int STR_MAIN_LO     = 0;   // main strength lsb .. msb
    localparam int STR_UNUSED_BIT  = 7;   // unused, reads zero

    // error kind bits carried with a decoder event
    localparam int ERR_FRAMING = 0;
    localparam int ERR_SOF     = 1;
    localparam int ERR_EOF     = 2;
    localparam int ERR_PARITY  = 3;
    localparam int ERR_CRC     = 4;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // oscillator settle time and clock rate
    localparam int OSC_SETTLE_NS = 200_000;   // about 200 us
    localparam int CLK_PERIOD_NS = 10;        // 100 MHz
    localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // strength code: 7 steps, each roughly 4 dB (x1.585) above the last
    localparam int STEP_COUNT = 7;
    localparam logic [7:0] STEP_THRESH [STEP_COUNT] = '{
        8'h04, 8'h06, 8'h0A, 8'h10, 8'h19, 8'h28, 8'h3F
    };

    // decoder event: collision or reception error at a bit index
    typedef struct packed {
        logic       valid;      // one-cycle pulse
        logic       is_error;   // 1: reception error, 0: collision
        logic [4:0] err_kind;   // framing, sof, eof, parity, crc
        logic [9:0] bit_index;  // bit position of the event
    } crs_dec_evt_s;

    // convert a level into the 3-bit strength code
    function automatic logic [2:0] level_to_code(input logic [7:0] level);
        logic [2:0] code;
        code = 3'h0;
        for (int i = 0; i < STEP_COUNT; i++) begin
            if (level >= STEP_THRESH[i]) begin
                code = 3'(i + 1);
            end
        end
        return code;
    endfunction

endpackage

/* File: rtl/crs_peak_hold.sv */
// peak latch and strength coder for one receive channel
`timescale 1ns/1ps
module crs_peak_hold (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clear,      // start of transmission or power-down
    input  wire logic       enable,     // inside the measuring window
    input  wire logic       abs_mode,   // rf amplitude: sample is the level itself
    input  wire logic [7:0] sample,     // one-sided envelope sample
    output logic      [2:0] code        // latched strength code
);

    logic [7:0] max_q, max_d;    // highest sample in window
    logic [7:0] min_q, min_d;    // lowest sample in window
    logic [2:0] code_q, code_d;  // latched peak code
    logic [7:0] level;           // level fed to the coder
    logic [2:0] new_code;        // code of this sample

    // track extremes, code the level, keep only the peak
    always_comb begin
        max_d    = max_q;
        min_d    = min_q;
        code_d   = code_q;
        level    = 8'h00;
        new_code = 3'h0;
        if (clear) begin
            // cleared at transmit start so the next response is fresh
            max_d  = 8'h00;
            min_d  = 8'hFF;
            code_d = 3'h0;
        end else if (enable) begin
            max_d = (sample > max_q) ? sample : max_q;
            min_d = (sample < min_q) ? sample : min_q;
            // peak-to-peak of the one side we are fed
            level = abs_mode ? sample : (max_d - min_d);
            new_code = crs_pkg::level_to_code(level);
            // hold the peak so software can read after the packet ends
            if (new_code > code_q) begin
                code_d = new_code;
            end
        end
    end

    // register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_q  <= 8'h00;
            min_q  <= 8'hFF;
            code_q <= 3'h0;
        end else begin
            max_q  <= max_d;
            min_q  <= min_d;
            code_q <= code_d;
        end
    end

    assign code = code_q;

endmodule

/* File: bench/crs_status_bank_properties.sv */
// checker: bus answers and status read values of the status bank
`timescale 1ns/1ps
module crs_status_bank_properties (
    input wire logic                  aclk, aresetn, por_pin, chip_enable_pin,
    input wire logic                  proto_is_14443a, rx_start, tx_start, rf_amp_meas,
    input wire crs_pkg::crs_dec_evt_s dec_evt,
    input wire logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic                  s_axi_wready, s_axi_bvalid,
    input wire logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [7:0]            s_axi_araddr,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] a_q, clash_q, rd_q;   // read address, shadow clash, clash at read accept
    logic [1:0] top_q;                // shadow of top index bits
    logic       clr_q, sc_q;          // strengths known cleared, and at read accept
    wire off = por_pin || !chip_enable_pin;   // immediate; bench waits out the sync delay
    wire take = dec_evt.valid && (proto_is_14443a ? !dec_evt.is_error
                                                  : dec_evt.is_error && |dec_evt.err_kind);
    wire ar = s_axi_arvalid && s_axi_arready;
    // shadow state; an event beats the clear of a read in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || off) begin
            clash_q <= 8'h00;
            top_q <= 2'b00;
            clr_q <= 1'b1;
        end else begin
            if (take) clash_q <= dec_evt.bit_index[7:0];
            else if (ar && s_axi_araddr == 8'h38) clash_q <= 8'h00;
            if (take && proto_is_14443a) top_q <= dec_evt.bit_index[9:8];
            if (tx_start) clr_q <= 1'b1;
            else if (rx_start || rf_amp_meas) clr_q <= 1'b0;
        end
        if (ar) begin
            a_q <= s_axi_araddr;
            rd_q <= clash_q;
            sc_q <= clr_q;
        end
    end
    sequence ar_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    rd_latency_a: assert property (ar_take_s |=> s_axi_rvalid) else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    unmapped_err_a: assert property (s_axi_rvalid && !(a_q inside {8'h00, 8'h34, 8'h38, 8'h3C})
        |-> s_axi_rresp == crs_pkg::RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read");
    unused_bit_a: assert property (s_axi_rvalid && a_q == 8'h3C |-> !s_axi_rdata[7])
        else $error("unused strength bit set");
    clash_value_a: assert property (s_axi_rvalid && a_q == 8'h38 |-> s_axi_rdata[7:0] == rd_q)
        else $error("clash value wrong");
    clash_top_a: assert property (s_axi_rvalid && a_q == 8'h34 |-> s_axi_rdata[7:6] == top_q)
        else $error("top clash bits wrong");
    strength_clear_a: assert property (s_axi_rvalid && a_q == 8'h3C && sc_q |->
        s_axi_rdata[5:0] == 6'h00) else $error("strength not cleared");
endmodule
bind crs_status_bank crs_status_bank_properties u_props (.*);

/* File: bench/crs_status_bank_test.sv */
// testbench: status bank driven over its bus and status inputs, checked against a model
`timescale 1ns/1ps
module crs_status_bank_test;
    logic aclk = 0, aresetn = 0, por_pin = 0, chip_enable_pin = 1, proto_is_14443a = 1;
    logic rx_start = 0, tx_start = 0, rf_amp_meas = 0, field_on = 1, s_axi_rready = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rf_amp_level = '0;
    logic [7:0] first_receive_input = '0, second_receive_input = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;   // ignored by the slave
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    crs_pkg::crs_dec_evt_s dec_evt = '0;
    int err_total = 0, cmp_count = 0, v, w;
    int m_ctrl = 0, m_mask = 'h3E, m_top = 0, m_clash = 0, m_str = 0, m_osc = 0;  // model
    crs_status_bank #(.OSC_SETTLE(20)) DUT (.*);   // short settle keeps the run brief
    always #5 aclk = ~aclk;
    task automatic chk(string n, int e, logic [31:0] g);
        cmp_count++;
        if (g !== 32'(e)) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // model read value; -1 marks an unmapped place
    function automatic int ex(int a);
        case (a)
            'h00: return m_ctrl;
            'h34: return m_top * 64 + m_mask;
            'h38: return m_clash;
            'h3C: return m_osc * 64 + m_str;
            default: return -1;
        endcase
    endfunction
    // strength code of a level, from the step table
    function automatic int cd(int lv);
        cd = 0;
        for (int i = 0; i < crs_pkg::STEP_COUNT; i++) if (lv >= crs_pkg::STEP_THRESH[i]) cd = i + 1;
    endfunction
    task automatic rd(logic [7:0] a);
        int e;
        e = ex(a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        repeat (50) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        chk("rvalid", 1, s_axi_rvalid);
        chk("rdata", e < 0 ? 0 : e, s_axi_rdata);
        chk("rresp", e < 0 ? 2 : 0, 32'(s_axi_rresp));
        if (a == 8'h38) m_clash = 0;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        repeat (50) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        chk("bvalid", 1, s_axi_bvalid);
        chk("bresp", ex(a) < 0 ? 2 : 0, 32'(s_axi_bresp));
    endtask
    task automatic evt(logic er, logic [4:0] k, logic [9:0] i);
        @(posedge aclk);
        dec_evt <= {1'b1, er, k, i};
        @(posedge aclk);
        dec_evt <= '0;
    endtask
    task automatic txp;
        @(posedge aclk) tx_start <= 1;
        @(posedge aclk) tx_start <= 0;
        m_str = 0;
    endtask
    task automatic rxp;
        @(posedge aclk) rx_start <= 1;
        @(posedge aclk) rx_start <= 0;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        results;
    end
    initial begin
        void'($urandom(9398));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd('h3C);
        rd('h00);
        rd('h38);
        rd('h10);
        wr('h10, 'hFF);
        wr('h34, 'hFF);
        m_mask = 'h3F;
        rd('h34);
        $display("test reset done");
        for (int n = 0; n < 4; n++) begin
            v = $urandom % 1024;
            evt(0, 0, v[9:0]);
            m_clash = v % 256;
            m_top = v / 256;
            rd('h38);
            rd('h38);
            rd('h34);
        end
        $display("test collision done");
        // power-down by either pin clears clash and top bits and returns mask to its reset value
        for (int k = 0; k < 2; k++) begin
            evt(0, 0, 10'h2A5);
            @(posedge aclk);
            if (k == 0) por_pin <= 1;
            else chip_enable_pin <= 0;
            repeat (6) @(posedge aclk);
            por_pin <= 0;
            chip_enable_pin <= 1;
            repeat (30) @(posedge aclk);
            {m_clash, m_top, m_mask, m_osc} = {32'd0, 32'd0, 32'h3E, 32'd1};
            rd('h38);
            rd('h34);
        end
        $display("test power-down done");
        proto_is_14443a <= 0;
        for (int k = 0; k < 5; k++) begin
            v = $urandom % 256;
            evt(1, 5'(1 << k), v[9:0]);
            m_clash = v;
            rd('h38);
        end
        evt(1, 0, 10'h055);
        evt(0, 0, 10'h066);
        rd('h38);
        $display("test error done");
        for (int k = 0; k < 4; k++) begin
            wr('h00, {4'h0, k[0], 3'h0});
            m_ctrl = k[0] ? 8 : 0;
            v = $urandom % 256;
            w = $urandom % 256;
            txp;
            rxp;
            @(posedge aclk) {first_receive_input, second_receive_input} <= {v[7:0], w[7:0]};
            repeat (3) @(posedge aclk);
            m_str = k[0] ? cd(v) * 8 + cd(w) : cd(w) * 8 + cd(v);
            rd('h3C);
            txp;
            rd('h3C);
            {first_receive_input, second_receive_input} <= 16'h0000;
        end
        $display("test strength done");
        v = $urandom % 256;
        @(posedge aclk) {field_on, rf_amp_meas, rf_amp_level} <= {2'b01, v[7:0]};
        repeat (4) @(posedge aclk);
        m_str = cd(v);
        rd('h3C);
        @(posedge aclk) {field_on, rf_amp_meas} <= 2'b10;
        $display("test amplitude done");
        results;
    end
endmodule
